// ==== bench/udt_host_model.sv ====
// Host controller model: IN tokens, data capture and handshakes
module udt_host_model (
  input  wire logic       ref_clk,
  input  wire logic       cmdGo,
  input  wire logic [1:0] cmdEp,
  input  wire logic       cmdRetry,
  input  wire logic [3:0] ackDelay,
  input  wire logic       respNak,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       txEnd,
  output logic            tokValid,
  output logic      [1:0] tokEp,
  output logic            hostAck,
  output logic            hostRetry,
  output logic            gotNak,
  output int              rxCount,
  output int              doneCount
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rxBuf [64];
  int         k;
  initial begin
    {tokValid, tokEp, hostAck, hostRetry, gotNak} = '0;
    rxCount = 0;
    doneCount = 0;
    forever begin
      @(posedge ref_clk);
      if (cmdGo === 1'b1) begin
        @(negedge ref_clk);
        gotNak = 1'b0;
        rxCount = 0;
        tokValid = 1'b1;
        tokEp = cmdEp;
        @(negedge ref_clk);
        tokValid = 1'b0;
        // Released lines show the inverse, not a stale copy
        tokEp = ~tokEp;
        // Refusal is a one-cycle pulse, already standing at this edge
        if (respNak === 1'b1) gotNak = 1'b1;
        for (k = 0; k < 40 && !gotNak; k++) begin
          @(negedge ref_clk);
          if (respNak === 1'b1) begin
            gotNak = 1'b1;
            break;
          end
          if (txValid === 1'b1) begin
            rxBuf[rxCount] = txData;
            rxCount++;
          end
          if (txEnd === 1'b1) break;
        end
        if (txEnd === 1'b1) begin
          // Slow host stalls before its handshake
          repeat (ackDelay) @(negedge ref_clk);
          hostAck = ~cmdRetry;
          hostRetry = cmdRetry;
          @(negedge ref_clk);
          hostAck = 1'b0;
          hostRetry = 1'b0;
        end
        doneCount++;
      end
    end
  end
endmodule

// ==== bench/usb_device_in_endpoint_tx_tb.sv ====
// Self-checking bench for the device IN endpoint engine
module usb_device_in_endpoint_tx_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic               ref_clk, rst, hostMode, busSupplyEnable, loadValid, loadReady;
  logic               dblDisWrite, tokValid, respNak, txValid, txEnd, hostAck, hostRetry;
  logic               cmdGo, cmdRetry, gotNak, sawFull;
  logic [1:0]         tokEp, cmdEp;
  logic [3:0]         swReady, auto_ready_on_full_packet, splitEn, dblDisData, dblDisable, txReady;
  logic [3:0]         fifoNotEmpty, txIntr, ackDelay;
  logic [3:0][1:0]    epType;
  logic [3:0][15:0]   maxPacket;
  logic [3:0][11:0]   fifoStart;
  logic [3:0][12:0]   fifoSize;
  logic [7:0]         txData;
  udt_pkg::udt_load_s loadData;
  int                 miscompares, nChecks, rxCount, doneCount, cycles, n;
  int                 intrCnt [4];

  udt_in_ep u_udt_in_ep (.ref_clk, .rst, .hostMode, .busSupplyEnable, .loadValid,
    .loadReady, .loadData, .swReady, .auto_ready_on_full_packet, .splitEn, .epType, .maxPacket, .fifoStart,
    .fifoSize, .dblDisWrite, .dblDisData, .dblDisable, .txReady, .fifoNotEmpty, .txIntr,
    .tokValid, .tokEp, .respNak, .txValid, .txData, .txEnd, .hostAck, .hostRetry);
  udt_host_model u_udt_host_model (.ref_clk, .cmdGo, .cmdEp, .cmdRetry, .ackDelay,
    .respNak, .txValid, .txData, .txEnd, .tokValid, .tokEp, .hostAck, .hostRetry,
    .gotNak, .rxCount, .doneCount);

  always #12.5 ref_clk = ~ref_clk;
  // Interrupts are pulses, so tally them mid-cycle
  always @(negedge ref_clk) begin
    for (int e = 0; e < 4; e++) if (txIntr[e] === 1'b1) intrCnt[e]++;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finalReport();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic push(input logic [1:0] ep, input logic [7:0] d);
    int k;
    loadValid = 1'b1;
    loadData = {ep, d};
    for (k = 0; k < 300; k++) begin
      if (loadReady === 1'b1) break;
      sawFull = 1'b1;
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
  endtask
  task automatic loadBlock(input logic [1:0] ep, input logic [7:0] base, input int cnt);
    for (int i = 0; i < cnt; i++) push(ep, base + 8'(i));
    loadValid = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic mark(input int e);
    swReady[e] = 1'b1;
    @(negedge ref_clk);
    swReady[e] = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic send(input logic [1:0] ep, input logic retry, input logic [3:0] dly);
    int k;
    int d0;
    d0 = doneCount;
    cmdEp = ep;
    cmdRetry = retry;
    ackDelay = dly;
    cmdGo = 1'b1;
    @(negedge ref_clk);
    cmdGo = 1'b0;
    for (k = 0; k < 200 && doneCount == d0; k++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic checkRx(input logic [7:0] base, input logic [31:0] cnt);
    check(rxCount, cnt, "byte count");
    for (int i = 0; i < cnt; i++) check(u_udt_host_model.rxBuf[i], base + 8'(i), "byte");
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testReset();
    check(dblDisable, 4'hf, "disable reset");
    check({txReady, fifoNotEmpty, txIntr}, '0, "flags reset");
    check(busSupplyEnable, 1'b0, "supply off");
    $display("test reset done");
  endtask
  task automatic testHost();
    hostMode = 1'b1;
    @(negedge ref_clk);
    check(busSupplyEnable, 1'b1, "supply on");
    send(2'd2, 1'b0, 4'h0);
    check({gotNak, 8'(rxCount)}, '0, "host role quiet");
    hostMode = 1'b0;
    @(negedge ref_clk);
    check(busSupplyEnable, 1'b0, "supply off");
    $display("test host done");
  endtask
  task automatic testSingle();
    loadBlock(2'd1, 8'h10, 3);
    send(2'd1, 1'b0, 4'h0);
    check(gotNak, 1'b1, "nak before ready");
    check(txReady, 4'h0, "not ready unmarked");
    mark(1);
    check({txReady, fifoNotEmpty}, 8'h22, "marked");
    n = intrCnt[1];
    send(2'd1, 1'b0, 4'h2);
    checkRx(8'h10, 3);
    check({txReady, fifoNotEmpty}, 8'h00, "sent");
    check(intrCnt[1] - n + intrCnt[2] + intrCnt[3], 1, "one interrupt");
    $display("test single done");
  endtask
  task automatic testFill();
    sawFull = 1'b0;
    fork
      begin
        for (int i = 0; i < 24; i++) push(2'd2, 8'h40 + 8'(i));
        loadValid = 1'b0;
      end
      begin
        for (int k = 0; k < 200 && !sawFull; k++) @(negedge ref_clk);
        for (int j = 0; j < 6; j++) begin
          // Give the next block time to move out of the load queue
          repeat (8) @(negedge ref_clk);
          send(2'd2, 1'b0, 4'h3);
          checkRx(8'h40 + 8'(4 * j), 4);
        end
      end
    join
    check(sawFull, 1'b1, "queue refused");
    check(fifoNotEmpty, 4'h0, "drained");
    $display("test fill done");
  endtask
  task automatic testDouble();
    dblDisData = 4'h7;
    dblDisWrite = 1'b1;
    @(negedge ref_clk);
    dblDisWrite = 1'b0;
    @(negedge ref_clk);
    check(dblDisable, 4'h7, "disable write");
    n = intrCnt[3];
    loadBlock(2'd3, 8'h80, 4);
    mark(3);
    check({txReady[3], fifoNotEmpty[3], 8'(intrCnt[3] - n)}, 10'h101, "first");
    loadBlock(2'd3, 8'h90, 4);
    mark(3);
    check(txReady[3], 1'b1, "second ready");
    send(2'd3, 1'b0, 4'h0);
    checkRx(8'h80, 4);
    check({txReady[3], fifoNotEmpty[3], 8'(intrCnt[3] - n)}, 10'h102, "one left");
    send(2'd3, 1'b0, 4'h0);
    checkRx(8'h90, 4);
    check({txReady[3], fifoNotEmpty[3], 8'(intrCnt[3] - n)}, 10'h003, "both free");
    $display("test double done");
  endtask
  task automatic testSplit();
    splitEn = 4'h2;
    maxPacket[1] = 16'h1008;
    n = intrCnt[1];
    loadBlock(2'd1, 8'h20, 16);
    mark(1);
    send(2'd1, 1'b0, 4'h1);
    checkRx(8'h20, 8);
    check({fifoNotEmpty[1], 8'(intrCnt[1] - n)}, 9'h100, "half sent");
    send(2'd1, 1'b0, 4'h0);
    checkRx(8'h28, 8);
    check({fifoNotEmpty[1], 8'(intrCnt[1] - n)}, 9'h001, "block sent");
    splitEn = 4'h0;
    $display("test split done");
  endtask
  task automatic testCtrl();
    loadBlock(2'd0, 8'h30, 8);
    mark(0);
    check(txReady[0], 1'b1, "ep0 ready");
    send(2'd0, 1'b1, 4'h0);
    checkRx(8'h30, 8);
    check(txReady[0], 1'b1, "kept after retry");
    send(2'd0, 1'b0, 4'h0);
    checkRx(8'h30, 8);
    check({txReady[0], fifoNotEmpty[0]}, 2'b00, "ep0 done");
    $display("test ctrl done");
  endtask

  initial begin
    {ref_clk, hostMode, loadValid, dblDisWrite, cmdGo, cmdRetry, sawFull} = '0;
    rst = 1'b1;
    {loadData, swReady, splitEn, dblDisData, cmdEp, ackDelay} = '0;
    auto_ready_on_full_packet = 4'h4;
    epType = {2'b11, 2'b10, 2'b10, 2'b00};
    maxPacket = {16'h0004, 16'h0004, 16'h0010, 16'h0040};
    // Ep0 area is fixed, so these two entries must be ignored
    fifoStart = {12'h0c0, 12'h080, 12'h040, 12'h040};
    fifoSize = {13'h0010, 13'h0008, 13'h0040, 13'h0004};
    {miscompares, nChecks, cycles} = '0;
    intrCnt = '{default: 0};
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    testReset();
    testHost();
    testSingle();
    testFill();
    testDouble();
    testSplit();
    testCtrl();
    finalReport();
  end
endmodule

// ==== inc/udt_params.svh ====
// Constants for the device transmit endpoint block
`ifndef UDT_PARAMS_SVH
`define UDT_PARAMS_SVH

// ****************************************
// Endpoint 0 placement
// ****************************************
`define UDT_EP0_START     12'h000
`define UDT_EP0_SIZE      13'h0040

// ****************************************
// Max-packet field layout
// ****************************************
`define UDT_PAYLOAD_MSB   10
`define UDT_MULT_LSB      11
`define UDT_MULT_MSB      15

// ****************************************
// Reset values and depths
// ****************************************
`define UDT_DBL_DIS_RESET 4'hf
`define UDT_LOAD_DEPTH    16
`define UDT_RAM_BYTES     4096

`endif

// ==== inc/udt_pkg.sv ====
// Types shared by the device transmit endpoint block
package udt_pkg;

  // ****************************************
  // Endpoint transfer types
  // ****************************************
  typedef enum logic [1:0] {
    UDT_CONTROL = 2'b00,
    UDT_ISO     = 2'b01,
    UDT_BULK    = 2'b10,
    UDT_INTR    = 2'b11
  } udt_type_e;

  // ****************************************
  // Transmit sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    UDT_IDLE = 2'b00,
    UDT_SEND = 2'b01,
    UDT_WAIT = 2'b10
  } udt_tx_e;

  // One byte loaded by software, tagged with its endpoint
  typedef struct packed {
    logic [1:0] ep;
    logic [7:0] data;
  } udt_load_s;

endpackage

// ==== rtl/udt_fifo.sv ====
// Valid/ready FIFO for the software load stream
module udt_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire              pushOk = inValid && inReady;
  wire              popOk  = outValid && outReady;

  // Extra pointer bit tells full from empty
  assign inReady  = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr != rdPtr;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (pushOk) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= wrPtr + (AW+1)'(pushOk);
      rdPtr <= rdPtr + (AW+1)'(popOk);
    end
  end
endmodule

// ==== rtl/udt_in_ep.sv ====
// Device-side IN endpoint engine: load, ready handshake, buffering, splitting
`include "udt_params.svh"

// Operation
// - Host or device role at a time, never both; role may change at run time.
// - Drive supply power to the connector only while it is used as host.
// - IN tokens are served by the addressed endpoint's transmit state.
// - Endpoint 0 is the dedicated bidirectional control endpoint.
// - Bus events for an endpoint touch only that endpoint's status.
// - Endpoint 0 uses the lowest 64 bytes of packet RAM.
// - Endpoints 1 to 3 each have an independently typed IN half.
// - Start and size of the buffers of endpoints 1 to 3 are programmable.
// - Loading stops at the endpoint's max packet size.
// - Buffer under two packets holds one packet only.
// - Auto-ready marks a max-size packet; short packets need software.
// - Single buffering: sent packet clears ready and not-empty, raises interrupt.
// - Double buffering: first ready packet clears ready at once with interrupt.
// - Double buffering: each send clears ready, interrupts; not-empty shows queue.
// - Double-buffer disable bits are set at reset; software clears them.
// - Splitting decodes max packet as 11-bit payload and 5-bit multiplier.
// - Split block goes out as payload-sized bus packets, one packet to software.
// - Packets up to 2047 bytes (11-bit payload) and buffers up to 4096 bytes are supported.
// - An IN token to an endpoint with nothing ready gets NAK.
module udt_in_ep #(
  parameter int RAM_BYTES  = `UDT_RAM_BYTES,
  parameter int LOAD_DEPTH = `UDT_LOAD_DEPTH
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                hostMode,
  output logic                     busSupplyEnable,
  input  wire logic                loadValid,
  output logic                     loadReady,
  input  wire udt_pkg::udt_load_s  loadData,
  input  wire logic [3:0]          swReady,
  input  wire logic [3:0]          auto_ready_on_full_packet,
  input  wire logic [3:0]          splitEn,
  input  wire logic [3:0][1:0]     epType,
  input  wire logic [3:0][15:0]    maxPacket,
  input  wire logic [3:0][11:0]    fifoStart,
  input  wire logic [3:0][12:0]    fifoSize,
  input  wire logic                dblDisWrite,
  input  wire logic [3:0]          dblDisData,
  output logic      [3:0]          dblDisable,
  output logic      [3:0]          txReady,
  output logic      [3:0]          fifoNotEmpty,
  output logic      [3:0]          txIntr,
  input  wire logic                tokValid,
  input  wire logic [1:0]          tokEp,
  output logic                     respNak,
  output logic                     txValid,
  output logic      [7:0]          txData,
  output logic                     txEnd,
  input  wire logic                hostAck,
  input  wire logic                hostRetry
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]          ram [RAM_BYTES];
  udt_pkg::udt_tx_e    state;
  logic [1:0]          curEp;
  logic [15:0]         chunkLen;
  logic [15:0]         chunkLeft;
  logic [11:0]         txCur;
  logic [15:0]         lenQ [4][2];
  logic [3:0]          lenHead;
  logic [1:0]          pktCount [4];
  logic [15:0]         loadCnt [4];
  logic [12:0]         usedCnt [4];
  logic [11:0]         wrPtr [4];
  logic [11:0]         rdPtr [4];
  logic [11:0]         epStart [4];
  logic [12:0]         epSize [4];
  logic [10:0]         payload [4];
  logic [15:0]         pktSize [4];
  logic [1:0]          cap [4];
  logic [15:0]         loadLen [4];
  logic [3:0]          splitOn;
  logic [3:0]          wrE;
  logic [3:0]          mark;
  logic [3:0]          done;
  logic [3:0]          ackE;
  logic [3:0]          canLoad;
  udt_pkg::udt_load_s  foData;
  logic                foValid;
  logic                drainReady;
  wire                 drainFire = foValid && drainReady;
  wire                 ackNow    = (state == udt_pkg::UDT_WAIT) && hostAck;
  wire  [15:0]         headRem   = lenQ[curEp][lenHead[curEp]];
  wire                 sendDone  = ackNow && (headRem == chunkLen);
  wire  [15:0]         tokRem    = lenQ[tokEp][lenHead[tokEp]];
  wire  [15:0]         tokChunk  = (splitOn[tokEp] && tokRem > {5'h00, payload[tokEp]})
                                   ? {5'h00, payload[tokEp]} : tokRem;
  wire  [11:0]         wrAddr    = epStart[foData.ep] + wrPtr[foData.ep];
  wire  [11:0]         rdAddr    = epStart[curEp] + txCur;

  // Ring advance inside one endpoint's buffer region
  function automatic logic [11:0] wrapInc(input logic [11:0] ptr, input logic [12:0] size);
    logic [12:0] sum;
    sum = {1'b0, ptr} + 13'h0001;
    wrapInc = (sum >= size) ? 12'h000 : sum[11:0];
  endfunction

  // ****************************************
  // Load path
  // ****************************************
  assign busSupplyEnable = hostMode;
  assign drainReady      = canLoad[foData.ep];

  // Software may stall here; backpressure reaches loadReady
  udt_fifo #(
    .WIDTH ($bits(udt_pkg::udt_load_s)),
    .DEPTH (LOAD_DEPTH)
  ) u_load_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (loadValid),
    .inReady  (loadReady),
    .inData   (loadData),
    .outValid (foValid),
    .outReady (drainReady),
    .outData  (foData)
  );

  always_ff @(posedge ref_clk) begin
    if (drainFire) begin
      ram[wrAddr] <= foData.data;
    end
  end

  // ****************************************
  // Per-endpoint state
  // ****************************************
  for (genvar e = 0; e < 4; e++) begin : g_ep
    wire [4:0] mult  = maxPacket[e][`UDT_MULT_MSB:`UDT_MULT_LSB];
    wire [4:0] multN = (mult == 5'h00) ? 5'h01 : mult;
    wire [1:0] nextCount = pktCount[e] + {1'b0, mark[e]} - {1'b0, done[e]};

    // Endpoint 0 is pinned to the bottom of RAM; no split on control
    assign epStart[e] = (e == 0) ? `UDT_EP0_START : fifoStart[e];
    assign epSize[e]  = (e == 0) ? `UDT_EP0_SIZE : fifoSize[e];
    assign payload[e] = maxPacket[e][`UDT_PAYLOAD_MSB:0];
    assign splitOn[e] = splitEn[e] && (e != 0) && (epType[e] == udt_pkg::UDT_BULK);
    assign pktSize[e] = splitOn[e] ? ({5'h00, payload[e]} * {11'h000, multN})
                                   : {5'h00, payload[e]};
    assign cap[e]     = (!dblDisable[e] && {4'h0, epSize[e]} >= {pktSize[e], 1'b0})
                        ? 2'h2 : 2'h1;
    assign wrE[e]     = drainFire && (foData.ep == 2'(e));
    assign loadLen[e] = loadCnt[e] + {15'h0000, wrE[e]};
    assign mark[e]    = (swReady[e] || (wrE[e] && auto_ready_on_full_packet[e] && loadLen[e] == pktSize[e]))
                        && (pktCount[e] < cap[e]);
    assign ackE[e]    = ackNow && (curEp == 2'(e));
    assign done[e]    = sendDone && (curEp == 2'(e));
    assign canLoad[e] = !hostMode && (pktCount[e] < cap[e]) && (loadCnt[e] < pktSize[e])
                        && (usedCnt[e] < epSize[e]);
    assign fifoNotEmpty[e] = pktCount[e] != 2'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pktCount[e] <= 2'h0;
        loadCnt[e]  <= 16'h0000;
        usedCnt[e]  <= 13'h0000;
        wrPtr[e]    <= 12'h000;
        rdPtr[e]    <= 12'h000;
        txReady[e]  <= 1'b0;
        txIntr[e]   <= 1'b0;
        lenHead[e]  <= 1'b0;
        lenQ[e][0]  <= 16'h0000;
        lenQ[e][1]  <= 16'h0000;
      end else begin
        pktCount[e] <= nextCount;
        loadCnt[e]  <= mark[e] ? 16'h0000 : loadLen[e];
        usedCnt[e]  <= usedCnt[e] + {12'h000, wrE[e]} - (ackE[e] ? chunkLen[12:0] : 13'h0000);
        // Ready holds only when no slot is left; a send always releases it
        txReady[e]  <= mark[e] && (nextCount == cap[e]) ? 1'b1
                     : done[e] ? 1'b0 : txReady[e];
        txIntr[e]   <= done[e] || (mark[e] && nextCount < cap[e]);
        if (wrE[e]) begin
          wrPtr[e] <= wrapInc(wrPtr[e], epSize[e]);
        end
        if (mark[e]) begin
          lenQ[e][lenHead[e] ^ pktCount[e][0]] <= loadLen[e];
        end
        if (ackE[e]) begin
          rdPtr[e] <= txCur;
          if (done[e]) begin
            lenHead[e] <= ~lenHead[e];
          end else begin
            lenQ[e][lenHead[e]] <= headRem - chunkLen;
          end
        end
      end
    end

    // ****************************************
    // Endpoint checks
    // ****************************************
    property p_single_done;
      @(posedge ref_clk) disable iff (rst)
      done[e] && cap[e] == 2'h1 && !mark[e] |=> !txReady[e] && !fifoNotEmpty[e] && txIntr[e];
    endproperty
    a_single_done: assert property (p_single_done)
      else $error("single buffer send did not release endpoint");

    property p_dbl_first;
      @(posedge ref_clk) disable iff (rst)
      mark[e] && cap[e] == 2'h2 && pktCount[e] == 2'h0 && !done[e]
        |=> !txReady[e] && txIntr[e] && fifoNotEmpty[e] ##1 !txIntr[e];
    endproperty
    a_dbl_first: assert property (p_dbl_first)
      else $error("double buffer first packet not released at once");

    property p_auto_ready;
      @(posedge ref_clk) disable iff (rst)
      wrE[e] && auto_ready_on_full_packet[e] && loadLen[e] == pktSize[e] && pktCount[e] == 2'h0
        |=> fifoNotEmpty[e] && loadCnt[e] == 16'h0000;
    endproperty
    a_auto_ready: assert property (p_auto_ready)
      else $error("full packet not auto-marked");

    property p_max_load;
      @(posedge ref_clk) disable iff (rst)
      wrE[e] |-> loadCnt[e] < pktSize[e];
    endproperty
    a_max_load: assert property (p_max_load)
      else $error("byte loaded past max packet size");
  end

  // set at reset, written by software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dblDisable <= `UDT_DBL_DIS_RESET;
    end else if (dblDisWrite) begin
      dblDisable <= dblDisData;
    end
  end

  // ****************************************
  // Transmit sequencer
  // ****************************************
  always_ff @(posedge ref_clk) begin
    txData <= ram[rdAddr];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= udt_pkg::UDT_IDLE;
      curEp     <= 2'h0;
      chunkLen  <= 16'h0000;
      chunkLeft <= 16'h0000;
      txCur     <= 12'h000;
      respNak   <= 1'b0;
      txValid   <= 1'b0;
      txEnd     <= 1'b0;
    end else begin
      respNak <= 1'b0;
      txValid <= 1'b0;
      txEnd   <= 1'b0;
      case (state)
        udt_pkg::UDT_IDLE: begin
          if (tokValid && !hostMode) begin
            if (pktCount[tokEp] != 2'h0) begin
              curEp     <= tokEp;
              chunkLen  <= tokChunk;
              chunkLeft <= tokChunk;
              txCur     <= rdPtr[tokEp];
              state     <= udt_pkg::UDT_SEND;
            end else begin
              respNak <= 1'b1;
            end
          end
        end
        udt_pkg::UDT_SEND: begin
          if (chunkLeft != 16'h0000) begin
            txValid   <= 1'b1;
            txCur     <= wrapInc(txCur, epSize[curEp]);
            chunkLeft <= chunkLeft - 16'h0001;
          end else begin
            txEnd <= 1'b1;
            state <= udt_pkg::UDT_WAIT;
          end
        end
        udt_pkg::UDT_WAIT: begin
          // Retry leaves the read pointer untouched so the chunk is resent
          if (hostAck || hostRetry) begin
            state <= udt_pkg::UDT_IDLE;
          end
        end
        default: state <= udt_pkg::UDT_IDLE;
      endcase
    end
  end

  // ****************************************
  // Sequencer checks
  // ****************************************
  logic [15:0] sentCnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sentCnt <= 16'h0000;
    end else begin
      sentCnt <= txEnd ? 16'h0000 : sentCnt + {15'h0000, txValid};
    end
  end

  property p_nak;
    @(posedge ref_clk) disable iff (rst)
    state == udt_pkg::UDT_IDLE && tokValid && !hostMode && pktCount[tokEp] == 2'h0
      |=> respNak && state == udt_pkg::UDT_IDLE;
  endproperty
  a_nak: assert property (p_nak)
    else $error("token without ready packet not refused");

  property p_split_size;
    @(posedge ref_clk) disable iff (rst)
    txEnd && splitOn[curEp] |-> sentCnt <= {5'h00, payload[curEp]} && sentCnt == chunkLen;
  endproperty
  a_split_size: assert property (p_split_size)
    else $error("split bus packet size wrong");

  property p_host_quiet;
    @(posedge ref_clk) disable iff (rst)
    hostMode && state == udt_pkg::UDT_IDLE |=> !txValid && !respNak;
  endproperty
  a_host_quiet: assert property (p_host_quiet)
    else $error("device engine active in host role");

  property p_ep0_area;
    @(posedge ref_clk) disable iff (rst)
    drainFire && foData.ep == 2'h0 |-> {1'b0, wrAddr} < `UDT_EP0_SIZE;
  endproperty
  a_ep0_area: assert property (p_ep0_area)
    else $error("endpoint 0 wrote outside its area");
endmodule
